//--- shared/lumsp_pkg.sv
// constants and types for the line unit mode select and serial port
package lumsp_pkg;
  // register word and address widths
  localparam int DATA_W = 8;
  localparam int ADDR_W = 3;
  localparam logic [2:0] TOP_BIT = 3'h7;
  // bit counts of the two frame phases (last index)
  localparam logic [2:0] CMD_LAST = 3'h3;
  localparam logic [2:0] DAT_LAST = 3'h7;
  // command register offsets
  localparam logic [2:0] CFG_OFS = 3'h0;
  localparam logic [2:0] STAT_OFS = 3'h1;
  // config register layout and reset value
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam int CFG_E3_BIT = 0;
  localparam int CFG_SONET_BIT = 1;
  localparam int CFG_MUTE_BIT = 2;
  // status register layout
  localparam int ST_HOST_BIT = 0;
  localparam int ST_E3_BIT = 1;
  localparam int ST_SONET_BIT = 2;
  localparam int ST_MUTE_BIT = 3;
  localparam int ST_LOS_BIT = 4;
  // recovery loop centre frequency in kHz
  localparam logic [15:0] PLL_SONET_KHZ = 16'hCA80;
  localparam logic [15:0] PLL_DS3_KHZ = 16'hAEC0;
  localparam logic [15:0] PLL_RST_KHZ = 16'h0000;
  // line rate, one-hot
  typedef enum logic [2:0] {
    RATE_DS3   = 3'h1,
    RATE_SONET = 3'h2,
    RATE_E3    = 3'h4
  } lumsp_rate_e;
  // serial frame phase, one-hot
  typedef enum logic [2:0] {
    LS_CMD  = 3'h1,
    LS_DATA = 3'h2,
    LS_DONE = 3'h4
  } lumsp_link_e;
endpackage

//--- verilog/lumsp_top.sv
// line unit mode select, rate select, loss mute and serial command port
// Functional notes
// - sonet select high gives 51.84 MHz loop centre, low gives 44.736 MHz.
// - sonet select is ignored while europe select is high.
// - europe select high means E3; low lets sonet select choose rate.
// - in host mode both rate pins are ignored.
// - mode select high enables serial port; config comes from command registers.
// - in host mode discrete configuration pins are ignored.
// - mode select low disables serial port; discrete pins take effect.
// - shared input is serial data in host mode, mute enable otherwise.
// - serial data is sampled on each rising serial clock edge.
// - mute enabled grounds both recovered data outputs during signal loss.
// - mute disabled keeps recovered data flowing during signal loss.
// - read data shifts out, changing on falling serial clock edges.
// - serial output released once the transfer has completed.
// - register reset low in host mode restores command register defaults.
//
// Chosen here: the register offsets and the address-and-strobe port.
module lumsp_top (
  // system clock and reset
  input  wire logic        clock_i,
  input  wire logic        nrst_i,
  // local register port
  input  wire logic [2:0]  addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [7:0]  rdata_o,
  // strap and discrete pins
  input  wire logic        interface_mode_select_i,
  input  wire logic        europe_rate_select_i,
  input  wire logic        sonet_rate_select_i,
  input  wire logic        command_register_reset_n_i,
  // serial port pins
  input  wire logic        serial_clock_i,
  input  wire logic        chip_select_n_i,
  input  wire logic        serial_in_i,
  output logic             serial_out_o,
  output logic             serial_out_oe_o,
  // receive path
  input  wire logic        los_i,
  input  wire logic        rec_pos_i,
  input  wire logic        rec_neg_i,
  output logic             recovered_positive_data_o,
  output logic             recovered_negative_data_o,
  // resulting configuration
  output logic             host_mode_o,
  output logic      [2:0]  rate_o,
  output logic      [15:0] pll_centre_khz_o
);

  // pin synchronisers, system side
  logic [4:0] pin_s1_q;
  logic [4:0] pin_s2_q;
  logic       host_s;
  logic       europe_s;
  logic       sonet_s;
  logic       regrst_n_s;
  logic       mute_pin_s;

  // command registers and effective settings
  logic [7:0] cfg_q;
  logic [7:0] stat_w;
  logic       e3_w;
  logic       sonet_w;
  logic       mute_w;
  logic [2:0] rate_d;
  logic [2:0] rate_q;
  logic [15:0] pll_d;
  logic [15:0] pll_q;
  logic       pos_q;
  logic       neg_q;
  logic [7:0] rdata_q;

  // write crossing, link to system
  logic       wreq_s1_q;
  logic       wreq_s2_q;
  logic       wreq_s3_q;
  logic       ser_wr;

  // snapshot crossing, system to link
  logic [7:0] snap_cfg_q;
  logic [7:0] snap_stat_q;
  logic       cs_s1_q;
  logic       cs_s2_q;

  // link domain state
  lumsp_pkg::lumsp_link_e state_q;
  logic [2:0] cnt_q;
  logic [3:0] cmd_q;
  logic [7:0] wdat_q;
  logic       rw_q;
  logic [2:0] addr_q;
  logic [7:0] rd_word_q;
  logic       wreq_q;
  logic [2:0] wr_addr_q;
  logic [7:0] wr_data_q;
  logic       host_l1_q;
  logic       host_l2_q;
  logic [7:0] copy_cfg_q;
  logic [7:0] copy_stat_q;
  logic       sout_q;
  logic       oe_q;

  // two flops on each strap pin and the shared input before system logic looks at it
  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      pin_s1_q <= 5'h08;
      pin_s2_q <= 5'h08;
    end
    else
    begin
      pin_s1_q <= {serial_in_i, command_register_reset_n_i,
                   sonet_rate_select_i, europe_rate_select_i,
                   interface_mode_select_i};
      pin_s2_q <= pin_s1_q;
    end
  end

  assign host_s     = pin_s2_q[0];
  assign europe_s   = pin_s2_q[1];
  assign sonet_s    = pin_s2_q[2];
  assign regrst_n_s = pin_s2_q[3];
  assign mute_pin_s = pin_s2_q[4];

  // effective settings: registers in host mode, pins otherwise
  always_comb
  begin
    if (host_s)
    begin
      e3_w    = cfg_q[lumsp_pkg::CFG_E3_BIT];
      sonet_w = cfg_q[lumsp_pkg::CFG_SONET_BIT];
      mute_w  = cfg_q[lumsp_pkg::CFG_MUTE_BIT];
    end
    else
    begin
      e3_w    = europe_s;
      sonet_w = sonet_s;
      mute_w  = mute_pin_s;
    end
    if (e3_w)
    begin
      rate_d = lumsp_pkg::RATE_E3;
      pll_d  = lumsp_pkg::PLL_DS3_KHZ;
    end
    else if (sonet_w)
    begin
      rate_d = lumsp_pkg::RATE_SONET;
      pll_d  = lumsp_pkg::PLL_SONET_KHZ;
    end
    else
    begin
      rate_d = lumsp_pkg::RATE_DS3;
      pll_d  = lumsp_pkg::PLL_DS3_KHZ;
    end
  end

  // status word seen by both readers
  always_comb
  begin
    stat_w = 8'h00;
    stat_w[lumsp_pkg::ST_HOST_BIT]  = host_s;
    stat_w[lumsp_pkg::ST_E3_BIT]    = e3_w;
    stat_w[lumsp_pkg::ST_SONET_BIT] = ~e3_w & sonet_w;
    stat_w[lumsp_pkg::ST_MUTE_BIT]  = mute_w;
    stat_w[lumsp_pkg::ST_LOS_BIT]   = los_i;
  end

  // registered rate and loop centre outputs
  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      rate_q <= lumsp_pkg::RATE_DS3;
      pll_q  <= lumsp_pkg::PLL_RST_KHZ;
    end
    else
    begin
      rate_q <= rate_d;
      pll_q  <= pll_d;
    end
  end

  // loss mute on the recovered data
  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      pos_q <= 1'b0;
      neg_q <= 1'b0;
    end
    else if (mute_w && los_i)
    begin
      pos_q <= 1'b0;
      neg_q <= 1'b0;
    end
    else
    begin
      pos_q <= rec_pos_i;
      neg_q <= rec_neg_i;
    end
  end

  // serial write request: rising edge of the synced level
  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      wreq_s1_q <= 1'b0;
      wreq_s2_q <= 1'b0;
      wreq_s3_q <= 1'b0;
    end
    else
    begin
      wreq_s1_q <= wreq_q;
      wreq_s2_q <= wreq_s1_q;
      wreq_s3_q <= wreq_s2_q;
    end
  end

  // hold registers are stable long before the request arrives
  assign ser_wr = wreq_s2_q & ~wreq_s3_q & host_s;

  // config register; same-address bus write beats a serial one
  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
      cfg_q <= lumsp_pkg::CFG_RST;
    else if (host_s && !regrst_n_s)
      cfg_q <= lumsp_pkg::CFG_RST;
    else if (wr_i && addr_i == lumsp_pkg::CFG_OFS)
      cfg_q <= wdata_i;
    else if (ser_wr && wr_addr_q == lumsp_pkg::CFG_OFS)
      cfg_q <= wr_data_q;
  end

  // local read port, data in the following cycle only
  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
      rdata_q <= 8'h00;
    else if (rd_i && addr_i == lumsp_pkg::CFG_OFS)
      rdata_q <= cfg_q;
    else if (rd_i && addr_i == lumsp_pkg::STAT_OFS)
      rdata_q <= stat_w;
    else
      rdata_q <= 8'h00;
  end

  // snapshot tracks the registers while the port is idle, frozen two cycles into a frame
  always_ff @(posedge clock_i)
  begin
    if (!nrst_i)
    begin
      cs_s1_q     <= 1'b1;
      cs_s2_q     <= 1'b1;
      snap_cfg_q  <= lumsp_pkg::CFG_RST;
      snap_stat_q <= 8'h00;
    end
    else
    begin
      cs_s1_q <= chip_select_n_i;
      cs_s2_q <= cs_s1_q;
      if (cs_s2_q)
      begin
        snap_cfg_q  <= cfg_q;
        snap_stat_q <= stat_w;
      end
    end
  end

  // link: mode level synchroniser
  always_ff @(posedge serial_clock_i)
  begin
    host_l1_q <= host_s;
    host_l2_q <= host_l1_q;
  end

  // snapshot copy; only used at address completion, when the snapshot is long frozen
  always_ff @(posedge serial_clock_i)
  begin
    copy_cfg_q  <= snap_cfg_q;
    copy_stat_q <= snap_stat_q;
  end

  // link: frame sequencer; chip select high clears it at once
  always_ff @(posedge serial_clock_i or posedge chip_select_n_i)
  begin
    if (chip_select_n_i)
    begin
      state_q <= lumsp_pkg::LS_CMD;
      cnt_q   <= 3'h0;
      wreq_q  <= 1'b0;
      rw_q    <= 1'b0;
      addr_q  <= 3'h0;
    end
    else
    begin
      case (state_q)
        lumsp_pkg::LS_CMD:
        begin
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == lumsp_pkg::CMD_LAST)
          begin
            state_q <= lumsp_pkg::LS_DATA;
            cnt_q   <= 3'h0;
            rw_q    <= cmd_q[2];
            addr_q  <= {cmd_q[1:0], serial_in_i};
          end
        end
        lumsp_pkg::LS_DATA:
        begin
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == lumsp_pkg::DAT_LAST)
          begin
            state_q <= lumsp_pkg::LS_DONE;
            wreq_q  <= ~rw_q;
          end
        end
        lumsp_pkg::LS_DONE:
          state_q <= lumsp_pkg::LS_DONE;
        default:
          state_q <= lumsp_pkg::LS_CMD;
      endcase
    end
  end

  // link: shift serial data in on rising edges
  always_ff @(posedge serial_clock_i)
  begin
    cmd_q  <= {cmd_q[2:0], serial_in_i};
    wdat_q <= {wdat_q[6:0], serial_in_i};
    if (state_q == lumsp_pkg::LS_DATA && cnt_q == lumsp_pkg::DAT_LAST)
    begin
      wr_addr_q <= addr_q;
      wr_data_q <= {wdat_q[6:0], serial_in_i};
    end
  end

  // link: latch the word to read as the address completes
  always_ff @(posedge serial_clock_i)
  begin
    if (state_q == lumsp_pkg::LS_CMD && cnt_q == lumsp_pkg::CMD_LAST)
    begin
      case ({cmd_q[1:0], serial_in_i})
        lumsp_pkg::CFG_OFS:  rd_word_q <= copy_cfg_q;
        lumsp_pkg::STAT_OFS: rd_word_q <= copy_stat_q;
        default:             rd_word_q <= 8'h00;
      endcase
    end
  end

  // link: read data on falling edges, msb first
  always_ff @(negedge serial_clock_i or posedge chip_select_n_i)
  begin
    if (chip_select_n_i)
    begin
      oe_q   <= 1'b0;
      sout_q <= 1'b0;
    end
    else
    begin
      oe_q  <= state_q == lumsp_pkg::LS_DATA && rw_q && host_l2_q;
      sout_q <= rd_word_q[lumsp_pkg::TOP_BIT - cnt_q];
    end
  end

  // outputs
  assign rdata_o                   = rdata_q;
  assign serial_out_o              = sout_q;
  assign serial_out_oe_o           = oe_q;
  assign recovered_positive_data_o = pos_q;
  assign recovered_negative_data_o = neg_q;
  assign host_mode_o               = host_s;
  assign rate_o                    = rate_q;
  assign pll_centre_khz_o          = pll_q;

  // checks, system domain
  mute_force_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    mute_w && los_i |=> !recovered_positive_data_o && !recovered_negative_data_o)
    else $error("recovered data not muted during loss");

  mute_pass_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    !mute_w |=> recovered_positive_data_o == $past(rec_pos_i))
    else $error("recovered data blocked while mute is off");

  e3_wins_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    !host_s && europe_s |=> rate_o == lumsp_pkg::RATE_E3)
    else $error("europe select did not force E3");

  pll_centre_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    !host_s && !europe_s && sonet_s |=> pll_centre_khz_o == lumsp_pkg::PLL_SONET_KHZ)
    else $error("sonet select did not set the sonet centre");

  host_pins_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    host_s && !cfg_q[lumsp_pkg::CFG_E3_BIT] && !cfg_q[lumsp_pkg::CFG_SONET_BIT]
    |=> rate_o == lumsp_pkg::RATE_DS3)
    else $error("rate pins took effect in host mode");

  reg_reset_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    host_s && !regrst_n_s |=> cfg_q == lumsp_pkg::CFG_RST)
    else $error("command register reset ignored");

  ser_write_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ser_wr && !wr_i && regrst_n_s && wr_addr_q == lumsp_pkg::CFG_OFS |=> cfg_q == $past(wr_data_q))
    else $error("serial write lost");

  hw_serial_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    !host_s && !wr_i && !(host_s && !regrst_n_s) |=> cfg_q == $past(cfg_q))
    else $error("config changed in hardware mode without bus write");

  // checks, link domain
  out_release_a: assert property (@(negedge serial_clock_i) disable iff (chip_select_n_i)
    state_q == lumsp_pkg::LS_DONE |=> !serial_out_oe_o)
    else $error("serial output still driven after transfer");

  out_drive_a: assert property (@(negedge serial_clock_i) disable iff (chip_select_n_i)
    state_q == lumsp_pkg::LS_DATA && rw_q && host_l2_q |=> serial_out_oe_o)
    else $error("serial output not driven during read");

  // main scenarios
  wr_seen_c: cover property (@(posedge clock_i) disable iff (!nrst_i) ser_wr);
  rd_seen_c: cover property (@(negedge serial_clock_i) disable iff (chip_select_n_i)
    serial_out_oe_o ##1 !serial_out_oe_o);
  mute_seen_c: cover property (@(posedge clock_i) disable iff (!nrst_i) mute_w && los_i);

endmodule

//--- verification/lumsp_host_model.sv
// host-side serial master model for the command port
module lumsp_host_model (
  // serial port pins
  output logic      serial_clock_o,
  output logic      chip_select_n_o,
  output logic      serial_in_o,
  input  wire logic serial_out_i,
  input  wire logic serial_out_oe_i
);
  timeunit 1ns;
  timeprecision 100ps;

  // clock stands still between frames
  initial
  begin
    serial_clock_o = 1'b0;
    chip_select_n_o = 1'b1;
    serial_in_o = 1'b0;
  end

  // one frame; nbits below 12 cuts it short, gap stretches each low phase
  task automatic xfer(input logic rw, input logic [2:0] a, input logic [7:0] d, input int nbits,
                      input int gap, output logic [7:0] q, output logic [7:0] oe);
    logic [11:0] bits;
    bits = {rw, a, d};
    q = 8'h00;
    oe = 8'h00;
    chip_select_n_o = 1'b0;
    #5;
    for (int i = 11; i > 11 - nbits; i--)
    begin
      serial_in_o = bits[i];
      #(7.5 + gap);
      if (i < 8)
      begin
        q[i] = serial_out_i;
        oe[i] = serial_out_oe_i;
      end
      serial_clock_o = 1'b1;
      #7.5;
      serial_clock_o = 1'b0;
    end
    #5;
    // released line must not keep the last bit
    serial_in_o = ~serial_in_o;
    chip_select_n_o = 1'b1;
    #40;
  endtask
endmodule

//--- verification/lumsp_top_tb_top.sv
// self-checking bench for the mode select and serial command port
module lumsp_top_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clock_i = 1'b0;
  logic        nrst = 1'b0;
  logic [2:0]  addr = 3'h0;
  logic [7:0]  wdata = 8'h00;
  logic        wr_s = 1'b0;
  logic        rd_s = 1'b0;
  logic        pend;
  logic [7:0]  rdata;
  logic        mode = 1'b0;
  logic        e3 = 1'b0;
  logic        so = 1'b0;
  logic        creg_n = 1'b1;
  logic        use_host = 1'b0;
  logic        mute_pin = 1'b0;
  logic        los = 1'b0;
  logic        rp = 1'b0;
  logic        rn = 1'b0;
  logic        sclk;
  logic        cs_n;
  logic        host_sin;
  logic        sout;
  logic        sout_oe;
  logic        rpo;
  logic        rno;
  logic        host_o;
  logic [2:0]  rate;
  logic [15:0] pll;
  logic [7:0]  q;
  logic [7:0]  oe;
  logic [7:0]  exp_q[$];
  int          errors = 0;
  int          compares = 0;

  // shared pin: serial data from the host, else the mute enable
  wire serial_in = use_host ? host_sin : mute_pin;

  always #5 clock_i = ~clock_i;

  lumsp_top lumsp_top_inst (
    .clock_i(clock_i), .nrst_i(nrst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr_s), .rd_i(rd_s),
    .rdata_o(rdata), .interface_mode_select_i(mode), .europe_rate_select_i(e3),
    .sonet_rate_select_i(so), .command_register_reset_n_i(creg_n), .serial_clock_i(sclk),
    .chip_select_n_i(cs_n), .serial_in_i(serial_in), .serial_out_o(sout), .serial_out_oe_o(sout_oe),
    .los_i(los), .rec_pos_i(rp), .rec_neg_i(rn), .recovered_positive_data_o(rpo),
    .recovered_negative_data_o(rno), .host_mode_o(host_o), .rate_o(rate), .pll_centre_khz_o(pll)
  );

  lumsp_host_model lumsp_host_model_inst (
    .serial_clock_o(sclk), .chip_select_n_o(cs_n), .serial_in_o(host_sin),
    .serial_out_i(sout), .serial_out_oe_i(sout_oe)
  );

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clock_i);
    wr_s <= 1'b0;
  endtask

  // read: the expected word is queued for the observer
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clock_i);
    exp_q.push_back(e);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clock_i);
    rd_s <= 1'b0;
  endtask

  // rate and centre after pins or config settle
  task automatic chk_rate(input logic [2:0] r, input logic [15:0] k);
    check("rate", {13'h0000, rate}, {13'h0000, r});
    check("pll", pll, k);
  endtask

  // read data stand only in the cycle after the strobe
  always @(posedge clock_i)
  begin
    pend = rd_s;
    #1;
    if (pend)
      check("rdata", {8'h00, rdata}, {8'h00, exp_q.pop_front()});
  end

  task automatic results();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // watchdog well beyond the few hundred cycles used
  initial
  begin
    #100us;
    errors++;
    results();
  end

  initial
  begin
    void'($urandom(32'h5C6D));
    tick(10);
    chk_rate(3'h1, 16'h0000);
    nrst <= 1'b1;
    tick(4);
    // hardware mode: every rate pin combination
    for (int k = 0; k < 4; k++)
    begin
      @(posedge clock_i);
      e3 <= k[1];
      so <= k[0];
      tick(5);
      chk_rate(k[1] ? 3'h4 : (k[0] ? 3'h2 : 3'h1),
               (k[0] && !k[1]) ? lumsp_pkg::PLL_SONET_KHZ : lumsp_pkg::PLL_DS3_KHZ);
      rd(lumsp_pkg::STAT_OFS, {5'h00, k[0] & !k[1], k[1], 1'b0});
    end
    $display("test hardware rate done");
    // mute on loss with the shared pin low then high
    for (int m = 0; m < 2; m++)
    begin
      @(posedge clock_i);
      mute_pin <= m[0];
      tick(4);
      repeat (16)
      begin
        @(posedge clock_i);
        {los, rp, rn} <= 3'($urandom);
        @(posedge clock_i);
        #1;
        check("rec", {14'h0000, rpo, rno}, (mute_pin & los) ? 16'h0000 : {14'h0000, rp, rn});
      end
    end
    $display("test hardware mute done");
    // host mode: pins driven high yet ignored
    @(posedge clock_i);
    {los, rp, rn} <= 3'h7;
    mode <= 1'b1;
    e3 <= 1'b1;
    so <= 1'b1;
    use_host <= 1'b1;
    tick(5);
    check("host", {15'h0000, host_o}, 16'h0001);
    chk_rate(3'h1, lumsp_pkg::PLL_DS3_KHZ);
    lumsp_host_model_inst.xfer(1'b0, lumsp_pkg::CFG_OFS, 8'h02, 12, 0, q, oe);
    tick(6);
    chk_rate(3'h2, lumsp_pkg::PLL_SONET_KHZ);
    lumsp_host_model_inst.xfer(1'b1, lumsp_pkg::CFG_OFS, 8'h00, 12, 0, q, oe);
    check("sread", {8'h00, q}, 16'h0002);
    check("soe", {8'h00, oe}, 16'h00FF);
    check("oe_end", {15'h0000, sout_oe}, 16'h0000);
    // cut-short frame must be discarded
    lumsp_host_model_inst.xfer(1'b0, lumsp_pkg::CFG_OFS, 8'h01, 8, 0, q, oe);
    tick(6);
    chk_rate(3'h2, lumsp_pkg::PLL_SONET_KHZ);
    // slow host sets mute bit; loss now mutes in host mode
    lumsp_host_model_inst.xfer(1'b0, lumsp_pkg::CFG_OFS, 8'h04, 12, 20, q, oe);
    tick(6);
    check("hmute", {14'h0000, rpo, rno}, 16'h0000);
    $display("test serial port done");
    // bus access, read-only and unmapped places
    @(posedge clock_i);
    los <= 1'b0;
    wr(lumsp_pkg::CFG_OFS, 8'h01);
    wr(lumsp_pkg::STAT_OFS, 8'hFF);
    wr(3'h5, 8'hFF);
    rd(lumsp_pkg::CFG_OFS, 8'h01);
    rd(3'h5, 8'h00);
    rd(lumsp_pkg::STAT_OFS, 8'h03);
    tick(3);
    chk_rate(3'h4, lumsp_pkg::PLL_DS3_KHZ);
    // register reset pin restores defaults
    @(posedge clock_i);
    creg_n <= 1'b0;
    tick(5);
    rd(lumsp_pkg::CFG_OFS, 8'h00);
    creg_n <= 1'b1;
    $display("test bus and reset done");
    // hardware mode: serial port shut, pins grounded for host use
    @(posedge clock_i);
    mode <= 1'b0;
    e3 <= 1'b0;
    so <= 1'b0;
    tick(5);
    lumsp_host_model_inst.xfer(1'b0, lumsp_pkg::CFG_OFS, 8'h02, 12, 0, q, oe);
    tick(6);
    chk_rate(3'h1, lumsp_pkg::PLL_DS3_KHZ);
    rd(lumsp_pkg::CFG_OFS, 8'h00);
    lumsp_host_model_inst.xfer(1'b1, lumsp_pkg::CFG_OFS, 8'h00, 12, 0, q, oe);
    check("hwoe", {8'h00, oe}, 16'h0000);
    $display("test hardware port off done");
    tick(4);
    results();
  end
endmodule
